// >>> bstap_pkg.sv
// Constants, opcodes and controller states for the boundary-scan test port.
// Assumes a single scan controller that owns the link clock and mode pins.
package bstap_pkg;

   // ----------------------------------------------------------------
   // Register lengths
   // ----------------------------------------------------------------
   localparam int IR_LEN = 10;
   localparam int ID_LEN = 32;
   localparam int BSR_LEN_DEF = 690;
   localparam int BSR_LEN_MAX = 1446;
   localparam int USER_BITS = 7;
   localparam int USER_FIXED_BITS = 25;

   // ----------------------------------------------------------------
   // Instruction register capture value and opcodes
   // ----------------------------------------------------------------
   localparam logic [IR_LEN-1:0] IR_CAPTURE = 10'h001;
   localparam logic [IR_LEN-1:0] OP_EXTEST = 10'h000;
   localparam logic [IR_LEN-1:0] OP_CFG_LOAD = 10'h002;
   localparam logic [IR_LEN-1:0] OP_CFG_START = 10'h003;
   localparam logic [IR_LEN-1:0] OP_SAMPLE = 10'h005;
   localparam logic [IR_LEN-1:0] OP_IDCODE = 10'h006;
   localparam logic [IR_LEN-1:0] OP_USERCODE = 10'h007;
   localparam logic [IR_LEN-1:0] OP_BYPASS = 10'h3FF;

   // ----------------------------------------------------------------
   // Identification word fields, values arbitrary
   // ----------------------------------------------------------------
   localparam logic [3:0] ID_VERSION = 4'h3;
   localparam logic [15:0] ID_PART = 16'h5A5A;
   localparam logic [10:0] ID_MAKER = 11'h2A5;
   localparam logic ID_LSB = 1'b1;
   localparam logic [24:0] USER_FIXED = 25'h0ACE5;
   localparam logic [6:0] USER_SIG_DEF = 7'h00;

   // ----------------------------------------------------------------
   // Data register selection and controller states
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      BSTAP_DR_BYPASS = 3'h0,
      BSTAP_DR_BSR = 3'h1,
      BSTAP_DR_ID = 3'h2,
      BSTAP_DR_USER = 3'h3,
      BSTAP_DR_CFG = 3'h4
   } bstap_dr_e;

   typedef enum logic [3:0] {
      BSTAP_TLR = 4'hF,
      BSTAP_RTI = 4'hC,
      BSTAP_SEL_DR = 4'h7,
      BSTAP_CAP_DR = 4'h6,
      BSTAP_SH_DR = 4'h2,
      BSTAP_EX1_DR = 4'h1,
      BSTAP_PA_DR = 4'h3,
      BSTAP_EX2_DR = 4'h0,
      BSTAP_UP_DR = 4'h5,
      BSTAP_SEL_IR = 4'h4,
      BSTAP_CAP_IR = 4'hE,
      BSTAP_SH_IR = 4'hA,
      BSTAP_EX1_IR = 4'h9,
      BSTAP_PA_IR = 4'hB,
      BSTAP_EX2_IR = 4'h8,
      BSTAP_UP_IR = 4'hD
   } bstap_state_e;

endpackage

// >>> bstap_bsr_chain.sv
// Boundary-scan register: capture, shift and update cells, one per pin.
// Assumes all control strobes come from the controller on the test clock.
`timescale 1ns/1ps
module bstap_bsr_chain
   import bstap_pkg::*;
#(
   parameter int LEN = BSR_LEN_DEF
) (
   // Clock and reset
   input wire logic i_tck,
   input wire logic i_reset_n,
   // Controller strobes
   input wire logic i_capture,
   input wire logic i_shift,
   input wire logic i_update,
   input wire logic i_tdi,
   // Pin side
   input wire logic [LEN-1:0] i_pin_in,
   output logic [LEN-1:0] o_test_out,
   output logic o_tdo_bit
);

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   // Pins are not related to the test clock, so each passes two flops.
   logic [LEN-1:0] pin_meta;
   logic [LEN-1:0] pin_sync;
   logic [LEN-1:0] shift_cells;

   always_ff @(posedge i_tck or negedge i_reset_n) begin
      if (!i_reset_n) begin
         pin_meta <= '0;
         pin_sync <= '0;
      end else begin
         pin_meta <= i_pin_in;
         pin_sync <= pin_meta;
      end
   end

   // ----------------------------------------------------------------
   // Cells
   // ----------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < LEN; g++) begin : g_cell
         always_ff @(posedge i_tck or negedge i_reset_n) begin
            if (!i_reset_n) begin
               shift_cells[g] <= 1'b0;
            end else if (i_capture) begin
               shift_cells[g] <= pin_sync[g];
            end else if (i_shift) begin
               shift_cells[g] <= (g == LEN - 1) ? i_tdi : shift_cells[(g + 1) % LEN];
            end
         end
         // The update stage keeps pins steady while new data shifts past.
         always_ff @(posedge i_tck or negedge i_reset_n) begin
            if (!i_reset_n) begin
               o_test_out[g] <= 1'b0;
            end else if (i_update) begin
               o_test_out[g] <= shift_cells[g];
            end
         end
      end
   endgenerate

   assign o_tdo_bit = shift_cells[0];

endmodule

// >>> bstap_top.sv
// Boundary-scan test access port with instruction and data registers.
// Assumes the scan controller drives the test clock; the system clock side
// reports configuration progress and receives mode levels.
`timescale 1ns/1ps
module bstap_top
   import bstap_pkg::*;
#(
   parameter int BSR_LEN = BSR_LEN_DEF,
   parameter logic [USER_BITS-1:0] USER_SIG = USER_SIG_DEF
) (
   // System clock domain
   input wire logic i_clk_sys,
   input wire logic i_reset_n,
   input wire logic i_cfg_busy,
   output logic o_extest_active,
   output logic o_cfg_scan_req,
   // Test link
   input wire logic i_tck,
   input wire logic i_tms,
   input wire logic i_tdi,
   output logic o_tdo,
   output logic o_tdo_oe,
   // Boundary pins
   input wire logic [BSR_LEN-1:0] i_pin_in,
   output logic [BSR_LEN-1:0] o_pin_test,
   output logic o_pin_force
);

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   localparam logic [ID_LEN-1:0] ID_WORD = {ID_VERSION, ID_PART, ID_MAKER, ID_LSB};
   localparam logic [ID_LEN-1:0] USER_WORD = {USER_SIG, USER_FIXED};

   bstap_state_e state;
   bstap_state_e next_state;
   bstap_dr_e dr_sel;
   logic [IR_LEN-1:0] ir;
   logic [IR_LEN-1:0] ir_shift;
   logic bypass_bit;
   logic cfg_bit;
   logic [ID_LEN-1:0] id_shift;
   logic [ID_LEN-1:0] user_shift;
   logic cfg_busy_sys;
   logic busy_meta;
   logic busy_tck;
   logic cfg_active_tck;
   logic force_meta;
   logic cfg_meta;
   logic bsr_tdo;
   logic dr_out;
   logic cap_dr;
   logic sh_dr;
   logic up_dr;

   // ----------------------------------------------------------------
   // Instruction decode
   // ----------------------------------------------------------------
   // Scan-test instructions fall back to bypass while the device
   // configures, so a stray extest cannot fight the loading logic.
   function automatic bstap_dr_e decode_dr(input logic [IR_LEN-1:0] op, input logic busy);
      bstap_dr_e sel;
      sel = BSTAP_DR_BYPASS;
      case (op)
         OP_EXTEST, OP_SAMPLE: sel = busy ? BSTAP_DR_BYPASS : BSTAP_DR_BSR;
         OP_IDCODE: sel = BSTAP_DR_ID;
         OP_USERCODE: sel = BSTAP_DR_USER;
         OP_CFG_LOAD, OP_CFG_START: sel = BSTAP_DR_CFG;
         default: sel = BSTAP_DR_BYPASS;
      endcase
      return sel;
   endfunction

   assign dr_sel = decode_dr(ir, busy_tck);
   assign cap_dr = (state == BSTAP_CAP_DR);
   assign sh_dr = (state == BSTAP_SH_DR);
   assign up_dr = (state == BSTAP_UP_DR);

   // ----------------------------------------------------------------
   // Configuration status crossing into the test clock
   // ----------------------------------------------------------------
   always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
      if (!i_reset_n) begin
         cfg_busy_sys <= 1'b0;
      end else begin
         cfg_busy_sys <= i_cfg_busy;
      end
   end

   always_ff @(posedge i_tck or negedge i_reset_n) begin
      if (!i_reset_n) begin
         busy_meta <= 1'b0;
         busy_tck <= 1'b0;
      end else begin
         busy_meta <= cfg_busy_sys;
         busy_tck <= busy_meta;
      end
   end

   // ----------------------------------------------------------------
   // Controller state machine
   // ----------------------------------------------------------------
   always_comb begin
      next_state = state;
      case (state)
         BSTAP_TLR: next_state = i_tms ? BSTAP_TLR : BSTAP_RTI;
         BSTAP_RTI: next_state = i_tms ? BSTAP_SEL_DR : BSTAP_RTI;
         BSTAP_SEL_DR: next_state = i_tms ? BSTAP_SEL_IR : BSTAP_CAP_DR;
         BSTAP_CAP_DR: next_state = i_tms ? BSTAP_EX1_DR : BSTAP_SH_DR;
         BSTAP_SH_DR: next_state = i_tms ? BSTAP_EX1_DR : BSTAP_SH_DR;
         BSTAP_EX1_DR: next_state = i_tms ? BSTAP_UP_DR : BSTAP_PA_DR;
         BSTAP_PA_DR: next_state = i_tms ? BSTAP_EX2_DR : BSTAP_PA_DR;
         BSTAP_EX2_DR: next_state = i_tms ? BSTAP_UP_DR : BSTAP_SH_DR;
         BSTAP_UP_DR: next_state = i_tms ? BSTAP_SEL_DR : BSTAP_RTI;
         BSTAP_SEL_IR: next_state = i_tms ? BSTAP_TLR : BSTAP_CAP_IR;
         BSTAP_CAP_IR: next_state = i_tms ? BSTAP_EX1_IR : BSTAP_SH_IR;
         BSTAP_SH_IR: next_state = i_tms ? BSTAP_EX1_IR : BSTAP_SH_IR;
         BSTAP_EX1_IR: next_state = i_tms ? BSTAP_UP_IR : BSTAP_PA_IR;
         BSTAP_PA_IR: next_state = i_tms ? BSTAP_EX2_IR : BSTAP_PA_IR;
         BSTAP_EX2_IR: next_state = i_tms ? BSTAP_UP_IR : BSTAP_SH_IR;
         BSTAP_UP_IR: next_state = i_tms ? BSTAP_SEL_DR : BSTAP_RTI;
         default: next_state = BSTAP_TLR;
      endcase
   end

   always_ff @(posedge i_tck or negedge i_reset_n) begin
      if (!i_reset_n) begin
         state <= BSTAP_TLR;
      end else begin
         state <= next_state;
      end
   end

   // ----------------------------------------------------------------
   // Instruction register
   // ----------------------------------------------------------------
   always_ff @(posedge i_tck or negedge i_reset_n) begin
      if (!i_reset_n) begin
         ir_shift <= IR_CAPTURE;
      end else if (state == BSTAP_CAP_IR) begin
         ir_shift <= IR_CAPTURE;
      end else if (state == BSTAP_SH_IR) begin
         ir_shift <= {i_tdi, ir_shift[IR_LEN-1:1]};
      end
   end

   always_ff @(posedge i_tck or negedge i_reset_n) begin
      if (!i_reset_n) begin
         ir <= OP_IDCODE;
      end else if (state == BSTAP_TLR) begin
         ir <= OP_IDCODE;
      end else if (state == BSTAP_UP_IR) begin
         ir <= ir_shift;
      end
   end

   // ----------------------------------------------------------------
   // Small data registers
   // ----------------------------------------------------------------
   always_ff @(posedge i_tck or negedge i_reset_n) begin
      if (!i_reset_n) begin
         bypass_bit <= 1'b0;
      end else if (cap_dr && dr_sel == BSTAP_DR_BYPASS) begin
         bypass_bit <= 1'b0;
      end else if (sh_dr && dr_sel == BSTAP_DR_BYPASS) begin
         bypass_bit <= i_tdi;
      end
   end

   // The loader behind this one-bit configuration stage runs on the system clock.
   always_ff @(posedge i_tck or negedge i_reset_n) begin
      if (!i_reset_n) begin
         cfg_bit <= 1'b0;
      end else if (sh_dr && dr_sel == BSTAP_DR_CFG) begin
         cfg_bit <= i_tdi;
      end
   end

   always_ff @(posedge i_tck or negedge i_reset_n) begin
      if (!i_reset_n) begin
         id_shift <= '0;
      end else if (cap_dr && dr_sel == BSTAP_DR_ID) begin
         id_shift <= ID_WORD;
      end else if (sh_dr && dr_sel == BSTAP_DR_ID) begin
         id_shift <= {i_tdi, id_shift[ID_LEN-1:1]};
      end
   end

   always_ff @(posedge i_tck or negedge i_reset_n) begin
      if (!i_reset_n) begin
         user_shift <= '0;
      end else if (cap_dr && dr_sel == BSTAP_DR_USER) begin
         user_shift <= USER_WORD;
      end else if (sh_dr && dr_sel == BSTAP_DR_USER) begin
         user_shift <= {i_tdi, user_shift[ID_LEN-1:1]};
      end
   end

   // ----------------------------------------------------------------
   // Boundary-scan register
   // ----------------------------------------------------------------
   bstap_bsr_chain #(
      .LEN(BSR_LEN)
   ) u_bsr (
      .i_tck(i_tck),
      .i_reset_n(i_reset_n),
      .i_capture(cap_dr && dr_sel == BSTAP_DR_BSR),
      .i_shift(sh_dr && dr_sel == BSTAP_DR_BSR),
      .i_update(up_dr && dr_sel == BSTAP_DR_BSR),
      .i_tdi(i_tdi),
      .i_pin_in(i_pin_in),
      .o_test_out(o_pin_test),
      .o_tdo_bit(bsr_tdo)
   );

   // Pins follow extest at the edge that loads it, since the clock may halt in idle.
   always_ff @(posedge i_tck or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_pin_force <= 1'b0;
      end else if (state == BSTAP_UP_IR) begin
         o_pin_force <= (ir_shift == OP_EXTEST) && !busy_tck;
      end else begin
         o_pin_force <= (ir == OP_EXTEST) && !busy_tck;
      end
   end

   always_ff @(posedge i_tck or negedge i_reset_n) begin
      if (!i_reset_n) begin
         cfg_active_tck <= 1'b0;
      end else if (state == BSTAP_UP_IR) begin
         cfg_active_tck <= (decode_dr(ir_shift, busy_tck) == BSTAP_DR_CFG);
      end else begin
         cfg_active_tck <= (dr_sel == BSTAP_DR_CFG);
      end
   end

   // ----------------------------------------------------------------
   // Test data out, changed on the falling test clock edge
   // ----------------------------------------------------------------
   always_comb begin
      case (dr_sel)
         BSTAP_DR_BSR: dr_out = bsr_tdo;
         BSTAP_DR_ID: dr_out = id_shift[0];
         BSTAP_DR_USER: dr_out = user_shift[0];
         BSTAP_DR_CFG: dr_out = cfg_bit;
         default: dr_out = bypass_bit;
      endcase
   end

   always_ff @(negedge i_tck or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_tdo <= 1'b0;
         o_tdo_oe <= 1'b0;
      end else begin
         o_tdo <= (state == BSTAP_SH_IR) ? ir_shift[0] : dr_out;
         o_tdo_oe <= (state == BSTAP_SH_IR) || sh_dr;
      end
   end

   // ----------------------------------------------------------------
   // Mode levels crossing back to the system clock
   // ----------------------------------------------------------------
   always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
      if (!i_reset_n) begin
         force_meta <= 1'b0;
         o_extest_active <= 1'b0;
         cfg_meta <= 1'b0;
         o_cfg_scan_req <= 1'b0;
      end else begin
         force_meta <= o_pin_force;
         o_extest_active <= force_meta;
         cfg_meta <= cfg_active_tck;
         o_cfg_scan_req <= cfg_meta;
      end
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   property p_five_tms_reset;
      @(posedge i_tck) disable iff (!i_reset_n)
      i_tms [*5] |=> (state == BSTAP_TLR);
   endproperty
   a_five_tms_reset: assert property (p_five_tms_reset)
      else $error("Five high mode bits did not reach reset state");

   property p_reset_selects_id;
      @(posedge i_tck) disable iff (!i_reset_n)
      (state == BSTAP_TLR) |=> (ir == OP_IDCODE && dr_sel == BSTAP_DR_ID);
   endproperty
   a_reset_selects_id: assert property (p_reset_selects_id)
      else $error("Reset state did not select identification register");

   property p_bypass_one_bit;
      @(posedge i_tck) disable iff (!i_reset_n)
      (sh_dr && dr_sel == BSTAP_DR_BYPASS) |=> (bypass_bit == $past(i_tdi));
   endproperty
   a_bypass_one_bit: assert property (p_bypass_one_bit)
      else $error("Bypass bit did not follow data in");

   property p_busy_blocks_test;
      @(posedge i_tck) disable iff (!i_reset_n)
      (busy_tck && $past(busy_tck)) |-> (!o_pin_force && dr_sel != BSTAP_DR_BSR);
   endproperty
   a_busy_blocks_test: assert property (p_busy_blocks_test)
      else $error("Scan test active during configuration");

   property p_ir_capture;
      @(posedge i_tck) disable iff (!i_reset_n)
      (state == BSTAP_CAP_IR) |=> (ir_shift == IR_CAPTURE);
   endproperty
   a_ir_capture: assert property (p_ir_capture)
      else $error("Instruction register did not capture its fixed value");

   property p_ir_update;
      @(posedge i_tck) disable iff (!i_reset_n)
      (state == BSTAP_UP_IR) |=> (ir == $past(ir_shift));
   endproperty
   a_ir_update: assert property (p_ir_update)
      else $error("Instruction not loaded on update");

   property p_id_word;
      @(posedge i_tck) disable iff (!i_reset_n)
      (cap_dr && dr_sel == BSTAP_DR_ID) |=> (id_shift[0] == 1'b1
         && id_shift[ID_LEN-1 -: 4] == ID_VERSION && id_shift[11:1] == ID_MAKER);
   endproperty
   a_id_word: assert property (p_id_word)
      else $error("Identification word captured wrongly");

   property p_user_word;
      @(posedge i_tck) disable iff (!i_reset_n)
      (cap_dr && dr_sel == BSTAP_DR_USER) |=> (user_shift[ID_LEN-1 -: USER_BITS] == USER_SIG
         && user_shift[USER_FIXED_BITS-1:0] == USER_FIXED);
   endproperty
   a_user_word: assert property (p_user_word)
      else $error("User signature captured wrongly");

   property p_tdo_quiet;
      @(posedge i_tck) disable iff (!i_reset_n)
      (state == BSTAP_TLR) [*2] |-> !o_tdo_oe;
   endproperty
   a_tdo_quiet: assert property (p_tdo_quiet)
      else $error("Data out driven outside shift states");

   property p_extest_force;
      @(posedge i_tck) disable iff (!i_reset_n)
      (ir == OP_EXTEST && !busy_tck && !$past(busy_tck)) |-> o_pin_force;
   endproperty
   a_extest_force: assert property (p_extest_force)
      else $error("Extest did not drive pattern onto pins");

endmodule

// >>> bstap_scan_ctrl.sv
// Scan controller model: drives the test clock, mode and data lines.
// Assumes the device takes mode and data on the rising test clock edge.
`timescale 1ns/1ps
module bstap_scan_ctrl
   import bstap_pkg::*;
#(
   parameter int BL = BSR_LEN_DEF
) (
   // Test link
   output logic o_tck,
   output logic o_tms,
   output logic o_tdi,
   input wire logic i_tdo
);
   // ----------------------------------------------------------------
   // Link driver
   // ----------------------------------------------------------------
   // The clock stands still between frames, so the device sees no edges there.
   initial begin
      o_tck = 1'b0;
      o_tms = 1'b1;
      o_tdi = 1'b1;
      #7;
      reset5();
   end

   task automatic tick(input logic ms, input logic di, output logic dout);
      o_tms = ms;
      o_tdi = di;
      #15 o_tck = 1'b1;
      dout = i_tdo;
      #15 o_tck = 1'b0;
   endtask

   task automatic reset5();
      logic d;
      repeat (5) tick(1'b1, 1'b1, d);
   endtask

   // Idle, select, capture, shift n bits with the last one exiting, update, idle.
   task automatic scan(input logic ir, input int n, input logic [BL-1:0] din,
         output logic [BL-1:0] dout);
      logic d;
      dout = '0;
      tick(1'b0, 1'b1, d);
      tick(1'b1, 1'b1, d);
      if (ir) begin
         tick(1'b1, 1'b1, d);
      end
      tick(1'b0, 1'b1, d);
      tick(1'b0, 1'b1, d);
      for (int i = 0; i < n; i++) begin
         tick(i == n - 1, din[i], dout[i]);
      end
      tick(1'b1, 1'b1, d);
      tick(1'b0, 1'b1, d);
   endtask
endmodule

// >>> testbench.sv
// Self-checking bench for the boundary-scan port.
// Assumes the controller model owns the test clock; the bench owns the system side.
`timescale 1ns/1ps
module testbench
   import bstap_pkg::*;
;
   localparam int BL = BSR_LEN_DEF;
   localparam logic [USER_BITS-1:0] USIG = 7'h5B;
   localparam logic [ID_LEN-1:0] IDW = {ID_VERSION, ID_PART, ID_MAKER, ID_LSB};
   localparam logic [IR_LEN-1:0] BYP [3] = '{OP_BYPASS, 10'h155, 10'h3FE};
   logic i_clk_sys, i_reset_n, i_cfg_busy, i_tck, i_tms, i_tdi, o_tdo, o_tdo_oe;
   logic o_extest_active, o_cfg_scan_req, o_pin_force;
   logic [BL-1:0] i_pin_in, o_pin_test, d, p1, p2, pins;
   int fail_count, n_checks;
   int cycles = 0;
   int seed = 32'h49c5;

   bstap_top #(.BSR_LEN(BL), .USER_SIG(USIG)) u_bstap_top (.i_clk_sys(i_clk_sys),
      .i_reset_n(i_reset_n), .i_cfg_busy(i_cfg_busy), .o_extest_active(o_extest_active),
      .o_cfg_scan_req(o_cfg_scan_req), .i_tck(i_tck), .i_tms(i_tms), .i_tdi(i_tdi),
      .o_tdo(o_tdo), .o_tdo_oe(o_tdo_oe), .i_pin_in(i_pin_in), .o_pin_test(o_pin_test),
      .o_pin_force(o_pin_force));
   // A released data out reads high, as its weak pull-up would set it.
   bstap_scan_ctrl #(.BL(BL)) u_bstap_scan_ctrl (.o_tck(i_tck), .o_tms(i_tms),
      .o_tdi(i_tdi), .i_tdo(o_tdo_oe ? o_tdo : 1'b1));

   // ----------------------------------------------------------------
   // Clock, timeout, helpers
   // ----------------------------------------------------------------
   initial begin
      i_clk_sys = 1'b0;
      forever #25 i_clk_sys = ~i_clk_sys;
   end

   // The run needs about 1200 cycles; the ceiling leaves wide margin.
   always @(posedge i_clk_sys) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         fail_count++;
         give_verdict();
      end
   end

   function automatic logic [BL-1:0] rvec();
      logic [BL-1:0] v;
      for (int i = 0; i < BL; i++) v[i] = 1'($random(seed));
      return v;
   endfunction

   function automatic logic [BL-1:0] exp_byp(input logic [BL-1:0] din, input int n);
      logic [BL-1:0] e;
      e = '0;
      for (int i = 1; i < n; i++) e[i] = din[i-1];
      return e;
   endfunction

   task automatic chk_v(input string nm, input logic [BL-1:0] exp, input logic [BL-1:0] got);
      n_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task automatic chk_b(input string nm, input logic exp, input logic got);
      n_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("[FAIL] %s expected %b seen %b", nm, exp, got);
      end
   endtask

   task automatic sc(input logic ir, input int n, input logic [BL-1:0] din);
      u_bstap_scan_ctrl.scan(ir, n, din, d);
   endtask

   task automatic ld(input logic [IR_LEN-1:0] op);
      sc(1'b1, IR_LEN, BL'(op));
      chk_v("ir_capture", BL'(IR_CAPTURE), d);
      chk_b("tdo_oe_idle", 1'b0, o_tdo_oe);
   endtask

   task automatic ws();
      repeat (4) @(posedge i_clk_sys);
   endtask

   task automatic give_verdict();
      if (fail_count == 0 && n_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   initial begin
      i_reset_n = 1'b0;
      i_cfg_busy = 1'b0;
      i_pin_in = '0;
      fail_count = 0;
      n_checks = 0;
      repeat (4) @(posedge i_clk_sys);
      i_reset_n <= 1'b1;
      pins = rvec();
      i_pin_in <= pins;
      ws();
      sc(1'b0, ID_LEN, rvec());
      chk_v("id_from_reset", BL'(IDW), d);
      ld(OP_IDCODE);
      sc(1'b0, ID_LEN, rvec());
      chk_v("idcode", BL'(IDW), d);
      ld(OP_USERCODE);
      sc(1'b0, ID_LEN, rvec());
      chk_v("usercode", BL'({USIG, USER_FIXED}), d);
      foreach (BYP[k]) begin
         ld(BYP[k]);
         p1 = rvec();
         sc(1'b0, 32, p1);
         chk_v("bypass", exp_byp(p1, 32), d);
      end
      p1 = rvec();
      ld(OP_SAMPLE);
      sc(1'b0, BL, p1);
      chk_v("sample_capture", pins, d);
      chk_v("preload", p1, o_pin_test);
      chk_b("sample_force", 1'b0, o_pin_force);
      pins = rvec();
      @(posedge i_clk_sys) i_pin_in <= pins;
      ld(OP_EXTEST);
      ws();
      chk_b("extest_force", 1'b1, o_pin_force);
      chk_b("extest_active", 1'b1, o_extest_active);
      chk_v("extest_drive", p1, o_pin_test);
      p2 = rvec();
      sc(1'b0, BL, p2);
      chk_v("extest_capture", pins, d);
      chk_v("extest_update", p2, o_pin_test);
      @(posedge i_clk_sys) i_cfg_busy <= 1'b1;
      ws();
      ld(OP_EXTEST);
      ws();
      chk_b("busy_force", 1'b0, o_pin_force);
      chk_b("busy_active", 1'b0, o_extest_active);
      p2 = rvec();
      sc(1'b0, 32, p2);
      chk_v("busy_bypass", exp_byp(p2, 32), d);
      @(posedge i_clk_sys) i_cfg_busy <= 1'b0;
      ws();
      ld(OP_CFG_LOAD);
      ws();
      chk_b("cfg_req", 1'b1, o_cfg_scan_req);
      ld(OP_BYPASS);
      ws();
      chk_b("cfg_req_off", 1'b0, o_cfg_scan_req);
      ld(OP_CFG_START);
      ws();
      chk_b("cfg_start_req", 1'b1, o_cfg_scan_req);
      ld(OP_USERCODE);
      u_bstap_scan_ctrl.reset5();
      sc(1'b0, ID_LEN, rvec());
      chk_v("id_after_mode_reset", BL'(IDW), d);
      give_verdict();
   end
endmodule
